// [rtl/lcjac_ctrl.sv]
// line-interface clock, jitter attenuator and alarm control with an AHB-Lite register slave
// assumes mode, select and reference pins are asynchronous; bus is single-word AHB-Lite
`include "lcjac_defines.svh"
module lcjac_ctrl #(
   parameter int CH = 8,
   parameter logic [15:0] T1_IN_KHZ [8] = '{default: `LCJAC_KHZ_T1},
   parameter logic [15:0] E1_IN_KHZ [8] = '{default: `LCJAC_KHZ_E1},
   parameter logic [15:0] T1_OUT_KHZ [8] = '{default: `LCJAC_KHZ_T1},
   parameter logic [15:0] E1_OUT_KHZ [8] = '{default: `LCJAC_KHZ_E1}
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic host_mode,
   input wire logic [1:0] jitter_path_select,
   input wire logic [2:0] synth_ratio_select,
   input wire logic [4:0] equalizer_code,
   input wire logic wire_gauge_select,
   input wire logic auto_ones_on_signal_loss,
   input wire logic t1_ref_clock_in,
   input wire logic e1_ref_clock_in,
   input wire logic [CH-1:0] signal_loss,
   input wire logic [CH-1:0] tx_line_clock,
   input wire logic [CH-1:0] tx_pulse_seen,
   input wire logic [CH-1:0] tx_short_detect,
   output logic jitter_atten_en,
   output logic jitter_atten_rx,
   output logic jitter_fifo_64,
   output logic jitter_bw_narrow,
   output logic synth_clock_out,
   output logic line_rate_e1,
   output logic [15:0] synth_in_khz,
   output logic [15:0] synth_out_khz,
   output logic gauge_26,
   output logic [CH-1:0] tx_all_ones,
   output logic [CH-1:0] driver_fail_flag,
   output logic irq
);
   localparam int PW = 15 + CH;

   typedef struct packed {
      logic [PW-1:0] s1;
      logic [PW-1:0] s2;
      logic a_valid;
      logic a_write;
      logic [11:0] a_addr;
      logic [31:0] rdata;
      logic [1:0] ctrl_ja;
      logic [2:0] syn_ratio;
      logic syn_rate;
      logic [2*CH-1:0] stat;
      logic [2*CH-1:0] mask;
      logic [CH-1:0] loss_d;
      logic [CH-1:0] fail_d;
      logic [1:0] ja;
      logic [2:0] ratio;
      logic rate;
      logic ref_clk;
      logic gauge;
      logic [CH-1:0] ones;
      logic [15:0] in_khz;
      logic [15:0] out_khz;
   } lcjac_top_st_t;

   lcjac_top_st_t st;
   lcjac_top_st_t next_st;

   logic p_host;
   logic [1:0] p_ja;
   logic [2:0] p_ratio;
   logic [4:0] p_eq;
   logic p_gauge;
   logic p_ones;
   logic p_t1;
   logic p_e1;
   logic [CH-1:0] p_loss;
   logic [2*CH-1:0] ev;
   logic [2*CH-1:0] w1c;
   lcjac_pkg::lcjac_sel_t wsel;
   lcjac_pkg::lcjac_ja_path_t path;

   // map a byte address onto a register
   function automatic lcjac_pkg::lcjac_sel_t reg_sel(input logic [11:0] a);
      if (a == `LCJAC_ADDR_CTRL) begin
         return lcjac_pkg::LCJAC_SEL_CTRL;
      end else if (a == `LCJAC_ADDR_STAT) begin
         return lcjac_pkg::LCJAC_SEL_STAT;
      end else if (a == `LCJAC_ADDR_MASK) begin
         return lcjac_pkg::LCJAC_SEL_MASK;
      end else if (a == `LCJAC_ADDR_STATE) begin
         return lcjac_pkg::LCJAC_SEL_STATE;
      end else if (a == {`LCJAC_SYNTH_IDX, 2'b00}) begin
         return lcjac_pkg::LCJAC_SEL_SYNTH;
      end else begin
         return lcjac_pkg::LCJAC_SEL_NONE;
      end
   endfunction

   // synchronised pin fields
   assign {p_host, p_ja, p_ratio, p_eq, p_gauge, p_ones, p_t1, p_e1, p_loss} = st.s2;
   assign wsel = reg_sel(st.a_addr);
   assign path = lcjac_pkg::lcjac_ja_path_t'(st.ja);

   lcjac_drvmon #(
      .CH(CH)
   ) u_drvmon (
      .hclk(hclk),
      .hresetn(hresetn),
      .tx_line_clock(tx_line_clock),
      .tx_pulse_seen(tx_pulse_seen),
      .tx_short_detect(tx_short_detect),
      .driver_fail_flag(driver_fail_flag)
   );

   // next state of the whole block
   always_comb begin
      next_st = st;
      next_st.s1 = {host_mode, jitter_path_select, synth_ratio_select, equalizer_code,
                    wire_gauge_select, auto_ones_on_signal_loss, t1_ref_clock_in,
                    e1_ref_clock_in, signal_loss};
      next_st.s2 = st.s1;
      if (p_host) begin
         next_st.ja = st.ctrl_ja;
         next_st.ratio = st.syn_ratio;
         next_st.rate = st.syn_rate;
      end else begin
         next_st.ja = p_ja;
         next_st.ratio = p_ratio;
         next_st.rate = p_eq[`LCJAC_EQ_E1_BIT];
      end
      next_st.ref_clk = st.rate ? p_e1 : p_t1;
      next_st.in_khz = st.rate ? E1_IN_KHZ[st.ratio] : T1_IN_KHZ[st.ratio];
      next_st.out_khz = st.rate ? E1_OUT_KHZ[st.ratio] : T1_OUT_KHZ[st.ratio];
      next_st.gauge = p_gauge;
      next_st.ones = p_ones ? p_loss : '0;
      // rising alarms become events
      ev = {p_loss & ~st.loss_d, driver_fail_flag & ~st.fail_d};
      next_st.loss_d = p_loss;
      next_st.fail_d = driver_fail_flag;
      // data phase write
      w1c = '0;
      if (st.a_valid && st.a_write) begin
         if (wsel == lcjac_pkg::LCJAC_SEL_CTRL) begin
            next_st.ctrl_ja = hwdata[1:0];
         end else if (wsel == lcjac_pkg::LCJAC_SEL_STAT) begin
            w1c = hwdata[2*CH-1:0];
         end else if (wsel == lcjac_pkg::LCJAC_SEL_MASK) begin
            next_st.mask = hwdata[2*CH-1:0];
         end else if (wsel == lcjac_pkg::LCJAC_SEL_SYNTH) begin
            next_st.syn_ratio = hwdata[2:0];
            next_st.syn_rate = hwdata[`LCJAC_SYN_RATE_BIT];
         end
      end
      // set wins over write-one clear
      next_st.stat = (st.stat & ~w1c) | ev;
      // address phase, read data captured here
      next_st.a_valid = 1'b0;
      if (hsel && hready && htrans[1]) begin
         next_st.a_valid = 1'b1;
         next_st.a_write = hwrite;
         next_st.a_addr = haddr;
         next_st.rdata = '0;
         if (!hwrite) begin
            case (reg_sel(haddr))
               lcjac_pkg::LCJAC_SEL_CTRL: next_st.rdata[1:0] = st.ctrl_ja;
               lcjac_pkg::LCJAC_SEL_STAT: next_st.rdata[2*CH-1:0] = st.stat;
               lcjac_pkg::LCJAC_SEL_MASK: next_st.rdata[2*CH-1:0] = st.mask;
               lcjac_pkg::LCJAC_SEL_STATE: next_st.rdata[2*CH+3:0] = {st.ja, p_host, st.rate, p_loss,
                                                                        driver_fail_flag};
               lcjac_pkg::LCJAC_SEL_SYNTH: next_st.rdata[3:0] = {st.syn_rate, st.syn_ratio};
               default: next_st.rdata = '0;
            endcase
         end
      end
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
         st.ctrl_ja <= `LCJAC_RST_CTRL;
         st.syn_ratio <= `LCJAC_RST_RATIO;
         st.syn_rate <= `LCJAC_RST_RATE;
         st.mask <= `LCJAC_RST_MASK;
      end else begin
         st <= next_st;
      end
   end

   // bus answers at once, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = st.rdata;

   assign jitter_atten_en = path != lcjac_pkg::LCJAC_JA_OFF;
   assign jitter_atten_rx = path == lcjac_pkg::LCJAC_JA_RX32 || path == lcjac_pkg::LCJAC_JA_RX64;
   assign jitter_fifo_64 = path == lcjac_pkg::LCJAC_JA_RX64;
   assign jitter_bw_narrow = path == lcjac_pkg::LCJAC_JA_RX64;

   assign line_rate_e1 = st.rate;
   assign synth_clock_out = st.ref_clk;
   assign synth_in_khz = st.in_khz;
   assign synth_out_khz = st.out_khz;
   assign gauge_26 = st.gauge;
   assign tx_all_ones = st.ones;
   assign irq = |(st.stat & st.mask);

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // decode, mode steering and alarm checks
   property p_ja_off;
      st.ja == 2'h0 |-> !jitter_atten_en && !jitter_atten_rx;
   endproperty
   a_ja_off: assert property (p_ja_off) else $error("attenuator on with code 00");
   property p_ja_tx;
      st.ja == 2'h1 |-> jitter_atten_en && !jitter_atten_rx && !jitter_fifo_64 && !jitter_bw_narrow;
   endproperty
   a_ja_tx: assert property (p_ja_tx) else $error("code 01 not transmit 32");
   property p_ja_rx64;
      st.ja == 2'h3 |-> jitter_atten_rx && jitter_fifo_64 && jitter_bw_narrow;
   endproperty
   a_ja_rx64: assert property (p_ja_rx64) else $error("code 11 not receive 64");
   property p_host_ratio;
      p_host ##1 p_host |-> st.ratio == $past(st.syn_ratio);
   endproperty
   a_host_ratio: assert property (p_host_ratio) else $error("host mode used ratio pins");
   property p_hw_rate;
      !p_host |=> line_rate_e1 == $past(p_eq[`LCJAC_EQ_E1_BIT]);
   endproperty
   a_hw_rate: assert property (p_hw_rate) else $error("rate not from equalizer code");
   property p_synth;
      ##1 synth_clock_out == ($past(st.rate) ? $past(p_e1) : $past(p_t1));
   endproperty
   a_synth: assert property (p_synth) else $error("wrong reference on synth output");
   property p_ones_sent;
      p_ones && p_loss[0] |=> tx_all_ones[0];
   endproperty
   a_ones_sent: assert property (p_ones_sent) else $error("all-ones not sent on loss");
   property p_ones_off;
      !p_ones |=> tx_all_ones == '0;
   endproperty
   a_ones_off: assert property (p_ones_off) else $error("all-ones sent while disabled");
   property p_set_wins;
      ev[0] |=> st.stat[0] && (!st.mask[0] || irq);
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost or irq missing");
   property p_ja_rx32;
      st.ja == 2'h2 |-> jitter_atten_en && jitter_atten_rx && !jitter_fifo_64 && !jitter_bw_narrow;
   endproperty
   a_ja_rx32: assert property (p_ja_rx32) else $error("code 10 not receive 32");
   property p_hw_ja;
      !p_host |=> st.ja == $past(p_ja);
   endproperty
   a_hw_ja: assert property (p_hw_ja) else $error("path not from select pins");
   property p_host_ja;
      p_host |=> st.ja == $past(st.ctrl_ja);
   endproperty
   a_host_ja: assert property (p_host_ja) else $error("host mode used path pins");
   property p_hw_ratio;
      !p_host |=> st.ratio == $past(p_ratio);
   endproperty
   a_hw_ratio: assert property (p_hw_ratio) else $error("ratio not from select pins");
   property p_gauge_sel;
      1'b1 |=> gauge_26 == $past(p_gauge);
   endproperty
   a_gauge_sel: assert property (p_gauge_sel) else $error("gauge output not from pin");
   // write-one clear without event
   property p_w1c;
      st.a_valid && st.a_write && wsel == lcjac_pkg::LCJAC_SEL_STAT && hwdata[0] && !ev[0] |=> !st.stat[0];
   endproperty
   a_w1c: assert property (p_w1c) else $error("status bit not cleared by write");
   c_irq: cover property (!irq ##1 irq);
   c_rx64: cover property (jitter_fifo_64);
   c_ones: cover property (tx_all_ones != '0);
   c_host: cover property (p_host && st.ja == 2'h3);
endmodule // lcjac_ctrl

// [rtl/lcjac_defines.svh]
// constants of the line-interface clock, jitter and alarm control block
// assumes inclusion by bare name from the rtl files of this block
// How it works
// - jitter path code zero switches the attenuator off
// - code 01 puts attenuator in transmit path, 32 deep, wide bandwidth
// - code 10 receive 32 deep wide; code 11 receive 64 deep narrow
// - synthesized clock output follows T1 or E1 rate of current mode
// - all eight channels share one line rate, no per-channel choice
// - hardware mode: three ratio pins steer the frequency synthesizer
// - hardware mode: reference rate comes from the equalizer code pins
// - host mode: ratio pins ignored, synthesizer register steers it instead
// - driver fail flag rises on a transmit driver short
// - driver fail flag rises after over 128 transmit clocks without pulse
// - auto ones high: channels with signal loss send all-ones AMI
// - auto ones low: no substitution; one setting for every channel
// - gauge pin high selects 26 gauge, low 22 and 24 gauge
`ifndef LCJAC_DEFINES_SVH
`define LCJAC_DEFINES_SVH
`define LCJAC_ADDR_CTRL 12'h000
`define LCJAC_ADDR_STAT 12'h004
`define LCJAC_ADDR_MASK 12'h008
`define LCJAC_ADDR_STATE 12'h00C
`define LCJAC_SYNTH_IDX 10'h081
`define LCJAC_RST_CTRL 2'h0
`define LCJAC_RST_RATIO 3'h0
`define LCJAC_RST_RATE 1'h0
`define LCJAC_RST_MASK 16'h0000
`define LCJAC_EQ_E1_BIT 4
`define LCJAC_SYN_RATE_BIT 3
`define LCJAC_NOPULSE_LIMIT 8'h80
`define LCJAC_KHZ_T1 16'h0608
`define LCJAC_KHZ_E1 16'h0800
`endif

// [rtl/lcjac_pkg.sv]
// types used by the control block; its driver monitor uses none of them
// assumes nothing beyond a SystemVerilog compiler
package lcjac_pkg;
   // where the jitter attenuator sits
   typedef enum logic [1:0] {
      LCJAC_JA_OFF,
      LCJAC_JA_TX32,
      LCJAC_JA_RX32,
      LCJAC_JA_RX64
   } lcjac_ja_path_t;
   // register selected by an address
   typedef enum logic [2:0] {
      LCJAC_SEL_NONE,
      LCJAC_SEL_CTRL,
      LCJAC_SEL_STAT,
      LCJAC_SEL_MASK,
      LCJAC_SEL_STATE,
      LCJAC_SEL_SYNTH
   } lcjac_sel_t;
endpackage

// [rtl/lcjac_drvmon.sv]
// per-channel transmit driver failure monitor
// assumes transmit clock, pulse and short inputs arrive from pins, asynchronous to hclk
`include "lcjac_defines.svh"
module lcjac_drvmon #(
   parameter int CH = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [CH-1:0] tx_line_clock,
   input wire logic [CH-1:0] tx_pulse_seen,
   input wire logic [CH-1:0] tx_short_detect,
   output logic [CH-1:0] driver_fail_flag
);
   typedef struct packed {
      logic [CH-1:0] clk_s1;
      logic [CH-1:0] clk_s2;
      logic [CH-1:0] clk_d;
      logic [CH-1:0] pul_s1;
      logic [CH-1:0] pul_s2;
      logic [CH-1:0] sh_s1;
      logic [CH-1:0] sh_s2;
      logic [CH-1:0][7:0] cnt;
      logic [CH-1:0] flag;
   } lcjac_mon_st_t;

   lcjac_mon_st_t st;
   lcjac_mon_st_t next_st;
   logic [CH-1:0] over_lim;

   // synchronise pins, count transmit clocks between pulses
   always_comb begin
      next_st = st;
      next_st.clk_s1 = tx_line_clock;
      next_st.clk_s2 = st.clk_s1;
      next_st.clk_d = st.clk_s2;
      next_st.pul_s1 = tx_pulse_seen;
      next_st.pul_s2 = st.pul_s1;
      next_st.sh_s1 = tx_short_detect;
      next_st.sh_s2 = st.sh_s1;
      for (int i = 0; i < CH; i++) begin
         over_lim[i] = st.cnt[i] > `LCJAC_NOPULSE_LIMIT;
         if (st.pul_s2[i]) begin
            next_st.cnt[i] = 8'h00;
         end else if (st.clk_s2[i] && !st.clk_d[i] && st.cnt[i] != 8'hFF) begin
            next_st.cnt[i] = st.cnt[i] + 8'h01; // saturates
         end
         next_st.flag[i] = st.sh_s2[i] | over_lim[i];
      end
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign driver_fail_flag = st.flag;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   property p_short_flag;
      st.sh_s2[0] |=> driver_fail_flag[0];
   endproperty
   a_short_flag: assert property (p_short_flag) else $error("short did not raise flag");
   property p_timeout;
      (st.cnt[0] == 8'h80) && !st.pul_s2[0] && st.clk_s2[0] && !st.clk_d[0] |=> ##1 driver_fail_flag[0];
   endproperty
   a_timeout: assert property (p_timeout) else $error("no-pulse timeout missed");
   property p_recover;
      st.pul_s2[0] && !st.sh_s2[0] ##1 !st.sh_s2[0] |=> !driver_fail_flag[0];
   endproperty
   a_recover: assert property (p_recover) else $error("flag stuck after pulses resumed");
   c_fail: cover property (!driver_fail_flag[0] ##1 driver_fail_flag[0]);
endmodule // lcjac_drvmon

// [sim/lcjac_framer_model.sv]
// far-side model: board reference oscillator and framer transmit side
// assumes hclk comes from the bench; tx clock runs at one eighth of hclk
module lcjac_framer_model (
   input wire logic hclk,
   input wire logic [7:0] pulses_on,
   output logic ref_clock,
   output logic [7:0] tx_line_clock,
   output logic [7:0] tx_pulse_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] div = 3'h0;
   // free-running oscillator near the t1 rate
   initial ref_clock = 1'b0;
   always #324 ref_clock = ~ref_clock;
   // transmit clock, one two-cycle pulse per period where enabled
   always @(posedge hclk) begin
      div <= div + 3'h1;
      tx_line_clock <= {8{div[2]}};
      tx_pulse_seen <= (div[2:1] == 2'h1) ? pulses_on : 8'h00;
   end
endmodule // lcjac_framer_model

// [sim/lcjac_ctrl_tb_top.sv]
// self-checking bench of the clock, jitter and alarm control block
// assumes the framer model beside it and the design under rtl/
module lcjac_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] T1_TAB [8] = '{16'h2000, 16'h2001, 16'h2002, 16'h2003,
      16'h2004, 16'h2005, 16'h2006, 16'h2007};
   localparam logic [15:0] E1_TAB [8] = '{16'h1000, 16'h1001, 16'h1002, 16'h1003,
      16'h1004, 16'h1005, 16'h1006, 16'h1007};
   localparam logic [3:0] JA_EXP [4] = '{4'h0, 4'h8, 4'hC, 4'hF};
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, host_mode = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0, jitter_path_select = 2'h0;
   logic [2:0] hsize = 3'h2, synth_ratio_select = 3'h0;
   logic [31:0] hwdata = 32'h0, rd;
   logic [4:0] equalizer_code = 5'h00;
   logic wire_gauge_select = 1'b0, auto_ones_on_signal_loss = 1'b0;
   logic [7:0] signal_loss = 8'h00, tx_short_detect = 8'h00, pulses_on = 8'hFF;
   wire logic hready, hreadyout, hresp, ref_clock, synth_clock_out, line_rate_e1, gauge_26, irq;
   wire logic jitter_atten_en, jitter_atten_rx, jitter_fifo_64, jitter_bw_narrow;
   wire logic [31:0] hrdata;
   wire logic [15:0] synth_in_khz, synth_out_khz;
   wire logic [7:0] tx_line_clock, tx_pulse_seen, tx_all_ones, driver_fail_flag;
   int num_errors = 0, checks_done = 0;
   assign hready = hreadyout;
   // clock of 20 ns period
   always #10 hclk = ~hclk;
   lcjac_framer_model i_lcjac_framer_model (.hclk(hclk), .pulses_on(pulses_on), .ref_clock(ref_clock),
      .tx_line_clock(tx_line_clock), .tx_pulse_seen(tx_pulse_seen));
   lcjac_ctrl #(.T1_IN_KHZ(T1_TAB), .E1_IN_KHZ(E1_TAB), .T1_OUT_KHZ(T1_TAB), .E1_OUT_KHZ(E1_TAB))
   i_lcjac_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .host_mode(host_mode), .jitter_path_select(jitter_path_select),
      .synth_ratio_select(synth_ratio_select), .equalizer_code(equalizer_code),
      .wire_gauge_select(wire_gauge_select), .auto_ones_on_signal_loss(auto_ones_on_signal_loss),
      .t1_ref_clock_in(ref_clock), .e1_ref_clock_in(ref_clock), .signal_loss(signal_loss),
      .tx_line_clock(tx_line_clock), .tx_pulse_seen(tx_pulse_seen), .tx_short_detect(tx_short_detect),
      .jitter_atten_en(jitter_atten_en), .jitter_atten_rx(jitter_atten_rx),
      .jitter_fifo_64(jitter_fifo_64), .jitter_bw_narrow(jitter_bw_narrow),
      .synth_clock_out(synth_clock_out), .line_rate_e1(line_rate_e1), .synth_in_khz(synth_in_khz),
      .synth_out_khz(synth_out_khz), .gauge_26(gauge_26), .tx_all_ones(tx_all_ones),
      .driver_fail_flag(driver_fail_flag), .irq(irq));
   // verdict and end of run
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // compare one value against its expectation
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // wait for ready at a rising edge, bounded
   task automatic wait_rdy();
      for (int i = 0; i < 50; i++) begin
         @(posedge hclk);
         if (hready === 1'b1) return;
      end
      num_errors++;
      $display("wrong value at %0t: bus ready never came", $time);
      wrap_up();
   endtask
   task automatic ahb_write(input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= 1'b1;
      wait_rdy();
      htrans <= 2'h0; hwdata <= d;
      wait_rdy();
   endtask
   task automatic ahb_read(input logic [11:0] a, output logic [31:0] d);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= 1'b0;
      wait_rdy();
      htrans <= 2'h0;
      wait_rdy();
      d = hrdata;
   endtask
   // reset values, bus response and an unmapped place
   task automatic t_reset();
      ahb_read(12'h000, rd); check(rd, 32'h0, "ctrl reset");
      ahb_read(12'h008, rd); check(rd, 32'h0, "mask reset");
      ahb_read(12'h204, rd); check(rd, 32'h0, "synth reset");
      ahb_write(12'h100, 32'hFFFF_FFFF); tick(1);
      ahb_read(12'h100, rd); check(rd, 32'h0, "unmapped read");
      check({31'h0, hresp}, 32'h0, "response okay");
      $display("test reset done");
   endtask
   // every jitter path code in hardware mode
   task automatic t_jitter_pins();
      for (int c = 0; c < 4; c++) begin
         jitter_path_select <= 2'(c); tick(6);
         check({jitter_atten_en, jitter_atten_rx, jitter_fifo_64, jitter_bw_narrow}, 32'(JA_EXP[c]), "ja");
      end
      jitter_path_select <= 2'h0;
      $display("test jitter pins done");
   endtask
   // register control in host mode, pins take over again afterwards
   task automatic t_host_synth();
      host_mode <= 1'b1; synth_ratio_select <= 3'h6; tick(6);
      ahb_write(12'h000, 32'h3); ahb_write(12'h204, 32'hA); tick(4);
      check({jitter_atten_rx, jitter_fifo_64, jitter_bw_narrow}, 32'h7, "host ja");
      check({31'h0, line_rate_e1}, 32'h1, "host rate");
      check({synth_in_khz, synth_out_khz}, {16'h1002, 16'h1002}, "host khz");
      host_mode <= 1'b0; synth_ratio_select <= 3'h5; equalizer_code <= 5'h0F; tick(8);
      check({15'h0, line_rate_e1, synth_out_khz}, {15'h0, 1'b0, 16'h2005}, "hw t1");
      equalizer_code <= 5'h10; tick(8);
      check({15'h0, line_rate_e1, synth_in_khz}, {15'h0, 1'b1, 16'h1005}, "hw e1");
      $display("test host synth done");
   endtask
   // synthesized clock keeps moving with the reference
   task automatic t_synth_clock();
      int n;
      logic prev;
      n = 0;
      prev = synth_clock_out;
      for (int i = 0; i < 100; i++) begin
         @(posedge hclk);
         if (synth_clock_out !== prev) n++;
         prev = synth_clock_out;
      end
      check(32'(n > 3), 32'h1, "synth clock toggles");
      $display("test synth clock done");
   endtask
   // gauge pin both levels
   task automatic t_gauge();
      wire_gauge_select <= 1'b1; tick(5); check({31'h0, gauge_26}, 32'h1, "gauge high");
      wire_gauge_select <= 1'b0; tick(5); check({31'h0, gauge_26}, 32'h0, "gauge low");
      $display("test gauge done");
   endtask
   // all-ones substitution under signal loss, and loss events
   task automatic t_all_ones();
      ahb_write(12'h004, 32'hFFFF);
      signal_loss <= 8'h05; auto_ones_on_signal_loss <= 1'b0; tick(5);
      check({24'h0, tx_all_ones}, 32'h0, "ones off");
      auto_ones_on_signal_loss <= 1'b1; tick(5);
      check({24'h0, tx_all_ones}, 32'h05, "ones on");
      ahb_read(12'h004, rd); check(rd, 32'h0500, "loss events");
      signal_loss <= 8'h00; tick(5);
      check({24'h0, tx_all_ones}, 32'h0, "ones released");
      ahb_write(12'h004, 32'hFFFF); auto_ones_on_signal_loss <= 1'b0;
      $display("test all ones done");
   endtask
   // short on one driver, interrupt masking and clearing
   task automatic t_short_irq();
      tx_short_detect <= 8'h04; tick(6);
      check({24'h0, driver_fail_flag}, 32'h04, "short flag");
      ahb_read(12'h00C, rd); check(rd, 32'h0001_0004, "state word");
      check({31'h0, irq}, 32'h0, "masked irq");
      ahb_write(12'h008, 32'h4); tick(1);
      check({31'h0, irq}, 32'h1, "irq raised");
      tx_short_detect <= 8'h00; tick(6);
      check({24'h0, driver_fail_flag}, 32'h0, "short gone");
      ahb_write(12'h004, 32'h4); tick(1);
      check({31'h0, irq}, 32'h0, "irq cleared");
      ahb_read(12'h004, rd); check(rd, 32'h0, "stat cleared");
      $display("test short irq done");
   endtask
   // missing pulses on channel 3 only, then recovery
   task automatic t_no_pulse();
      pulses_on <= 8'hF7; tick(800);
      check({24'h0, driver_fail_flag}, 32'h0, "early flag");
      tick(400);
      check({24'h0, driver_fail_flag}, 32'h08, "no pulse flag");
      pulses_on <= 8'hFF; tick(24);
      check({24'h0, driver_fail_flag}, 32'h0, "pulses back");
      $display("test no pulse done");
   endtask
   // main sequence
   initial begin
      tick(8);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_jitter_pins();
      t_host_synth();
      t_synth_clock();
      t_gauge();
      t_all_ones();
      t_short_irq();
      t_no_pulse();
      wrap_up();
   end
endmodule // lcjac_ctrl_tb_top
